// ==== logic/dwt_consts.vh ====
// constants and register map of the dual width timer
// Overview of operation
// - select 0 stops, 1 direct, 2..5 divided
// - select 6 falling, 7 rising pin edges
// - pin counts even when driven as output
// - sync hold keeps divider reset asserted
// - clearing sync hold releases all together
// - divider reset self clears unless hold
// - 8-bit registers, 16-bit joins B:A
// - four sources: overflow, A, B, capture
// - every source has flag and mask
// - increment per tick, wrap after top
// - processor count write beats counting
// - count readable and writable anytime
// - bottom zero, max FF or FFFF
// - top is max or compare value
// - width and waveform bits pick mode
// - capture modes use max, overflow at max
// - overflow set as count wraps from max to zero
// - overflow flag cleared when serviced
// - ctc clears after matching top
// - pin synchronised then edge detected
// - divider runs freely regardless of select
`ifndef DWT_CONSTS_VH
`define DWT_CONSTS_VH
// register byte addresses
`define DWT_ADDR_CTRL_A   8'h00
`define DWT_ADDR_CTRL_B   8'h04
`define DWT_ADDR_CNT_LO   8'h08
`define DWT_ADDR_CNT_HI   8'h0C
`define DWT_ADDR_CMP_A    8'h10
`define DWT_ADDR_CMP_B    8'h14
`define DWT_ADDR_FLAGS    8'h18
`define DWT_ADDR_MASK     8'h1C
`define DWT_ADDR_GENERAL  8'h20
// control a fields
`define DWT_WGM_BIT       0
`define DWT_WIDTH_BIT     1
`define DWT_CAPEN_BIT     2
// general control fields
`define DWT_HOLD_BIT      7
`define DWT_DIVRST_BIT    0
// flag and mask bit positions
`define DWT_OVF_BIT       0
`define DWT_MATCHA_BIT    1
`define DWT_MATCHB_BIT    2
`define DWT_CAPT_BIT      3
// tick source select codes
`define DWT_SEL_STOP      3'h0
`define DWT_SEL_DIRECT    3'h1
`define DWT_SEL_DIV8      3'h2
`define DWT_SEL_DIV64     3'h3
`define DWT_SEL_DIV256    3'h4
`define DWT_SEL_DIV1024   3'h5
`define DWT_SEL_PIN_FALL  3'h6
`define DWT_SEL_PIN_RISE  3'h7
// count limits
`define DWT_BOTTOM        16'h0000
`define DWT_MAX8          16'h00FF
`define DWT_MAX16         16'hFFFF
// reset values
`define DWT_RST_BYTE      8'h00
`define DWT_RST_CNT       16'h0000
`endif

// ==== logic/dwt_divider.v ====
// free-running shared divider producing tap enables
`timescale 1ns/100ps
`default_nettype none
module dwt_divider
(
  // clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // divider reset request
  input  wire       divider_reset,
  // one-cycle tap enables
  output wire       tap8,
  output wire       tap64,
  output wire       tap256,
  output wire       tap1024
);
  reg [9:0] div_cnt; // free-running divider count

  // runs regardless of tick source select
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt <= 10'h000;
    else if (divider_reset)
      div_cnt <= 10'h000;
    else
      div_cnt <= div_cnt + 10'h001;
  end

  // a tap pulses when its low bits are all ones
  assign tap8    = ~divider_reset & (&div_cnt[2:0]);
  assign tap64   = ~divider_reset & (&div_cnt[5:0]);
  assign tap256  = ~divider_reset & (&div_cnt[7:0]);
  assign tap1024 = ~divider_reset & (&div_cnt[9:0]);
endmodule
`default_nettype wire

// ==== logic/dwt_pin_edge.v ====
// external count pin synchroniser and edge detector
`timescale 1ns/100ps
`default_nettype none
module dwt_pin_edge
(
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // asynchronous pin level
  input  wire pin_in,
  // one-cycle edge pulses
  output wire rise,
  output wire fall
);
  reg sync1; // first stage, read only by sync2
  reg sync2; // synchronised level
  reg last;  // previous synchronised level

  // two-stage sync then one stage for edge
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      last  <= 1'b0;
    end
    else
    begin
      sync1 <= pin_in;
      sync2 <= sync1;
      last  <= sync2;
    end
  end

  // edges of the synchronised level
  assign rise = sync2 & ~last;
  assign fall = ~sync2 & last;
endmodule
`default_nettype wire

// ==== logic/dwt_timer.v ====
// dual width timer with apb registers and shared divider
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "dwt_consts.vh"
module dwt_timer
(
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // external count pin level
  input  wire        ext_count_pin,
  // capture trigger from same-clock logic
  input  wire        capture_event,
  // interrupt service acknowledges, one per source
  input  wire [3:0]  int_ack,
  // masked interrupt requests, one per source
  output reg  [3:0]  irq_req
);
  // software registers
  reg [2:0]  timer_control_a;   // waveform, width, capture
  reg [2:0]  tick_source_select; // timer_control_b
  reg        sync_hold_mode;    // general control bit 7
  reg        divider_reset;     // general control bit 0
  reg [15:0] count;             // count high and low byte
  reg [7:0]  compare_reg_a;     // compare low byte
  reg [7:0]  compare_reg_b;     // compare high byte
  reg [3:0]  timer_flag_reg;    // sticky event flags
  reg [3:0]  timer_mask_reg;    // per source enables

  // combinational next values
  reg [15:0] next_count;
  reg [3:0]  next_flags;
  reg        timer_tick;
  reg [31:0] next_rdata;
  reg        next_err;

  // decoded mode
  wire waveform_mode_bit;
  wire width_select;
  wire capture_mode_enable;
  wire ctc_mode;
  wire [15:0] max_val;
  wire [15:0] top_val;
  wire [15:0] cmp_word;
  wire at_max;
  wire at_top;
  wire match_a;
  wire match_b;

  // divider and pin edge outputs
  wire tap8;
  wire tap64;
  wire tap256;
  wire tap1024;
  wire pin_rise;
  wire pin_fall;

  // bus phases
  wire access;
  wire wr_en;
  wire [3:0] set_ev;
  wire [3:0] clr_ev;

  // shared free-running divider
  dwt_divider u_div
  (
    .pclk          (pclk),
    .presetn       (presetn),
    .divider_reset (divider_reset),
    .tap8          (tap8),
    .tap64         (tap64),
    .tap256        (tap256),
    .tap1024       (tap1024)
  );

  // pin edges; the pin level is sampled whatever its
  // direction, so software driving it also counts
  dwt_pin_edge u_pin
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (ext_count_pin),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  // mode fields
  assign waveform_mode_bit   = timer_control_a[`DWT_WGM_BIT];
  assign width_select        = timer_control_a[`DWT_WIDTH_BIT];
  assign capture_mode_enable = timer_control_a[`DWT_CAPEN_BIT];

  // ctc only without capture
  assign ctc_mode = waveform_mode_bit & ~capture_mode_enable;

  // max depends on width
  assign max_val = width_select ? `DWT_MAX16 : `DWT_MAX8;

  // compare word: b high, a low in wide mode
  assign cmp_word = width_select ?
                    {compare_reg_b, compare_reg_a} :
                    {8'h00, compare_reg_a};

  // top is compare in ctc, else max
  assign top_val = ctc_mode ? cmp_word : max_val;

  // limit and match detection
  assign at_max  = (count == max_val);
  assign at_top  = (count == top_val);
  assign match_a = (count == cmp_word);
  assign match_b = ~width_select &
                   (count[7:0] == compare_reg_b);

  // apb phases: pready rises one cycle into access
  assign access = psel & penable;
  assign wr_en  = access & pready & pwrite;

  // tick selection as a one-cycle enable
  always @*
  begin
    case (tick_source_select)
      `DWT_SEL_STOP:
        timer_tick = 1'b0;
      `DWT_SEL_DIRECT:
        timer_tick = ~divider_reset;
      `DWT_SEL_DIV8:
        timer_tick = tap8;
      `DWT_SEL_DIV64:
        timer_tick = tap64;
      `DWT_SEL_DIV256:
        timer_tick = tap256;
      `DWT_SEL_DIV1024:
        timer_tick = tap1024;
      `DWT_SEL_PIN_FALL:
        timer_tick = pin_fall;
      `DWT_SEL_PIN_RISE:
        timer_tick = pin_rise;
      default:
        timer_tick = 1'b0;
    endcase
  end

  // counter next value
  always @*
  begin
    next_count = count; // hold without tick
    if (timer_tick)
    begin
      // wrap past max, clear after ctc top
      if (at_max || at_top)
        next_count = `DWT_BOTTOM;
      else
        next_count = (count + 16'h0001) & max_val;
    end
    // processor write wins over counting
    if (wr_en && paddr == `DWT_ADDR_CNT_LO)
      next_count[7:0] = pwdata[7:0];
    if (wr_en && paddr == `DWT_ADDR_CNT_HI)
      next_count[15:8] = pwdata[7:0];
  end

  // counter register
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= `DWT_RST_CNT;
    else
      count <= next_count;
  end

  // event sources
  assign set_ev[`DWT_OVF_BIT]    = timer_tick & at_max;
  assign set_ev[`DWT_MATCHA_BIT] = timer_tick & match_a &
                                   ~capture_mode_enable;
  assign set_ev[`DWT_MATCHB_BIT] = timer_tick & match_b;
  assign set_ev[`DWT_CAPT_BIT]   = capture_event &
                                   capture_mode_enable;

  // clear by writing one, or by service acknowledge
  assign clr_ev = int_ack |
                  ((wr_en && paddr == `DWT_ADDR_FLAGS) ?
                   pwdata[3:0] : 4'h0);

  // per flag: set wins over clear
  genvar fi;
  generate
    for (fi = 0; fi < 4; fi = fi + 1)
    begin : g_flag
      always @*
      begin
        if (set_ev[fi])
          next_flags[fi] = 1'b1;
        else if (clr_ev[fi])
          next_flags[fi] = 1'b0;
        else
          next_flags[fi] = timer_flag_reg[fi];
      end
    end
  endgenerate

  // flags and masked requests
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_flag_reg <= 4'h0;
      irq_req        <= 4'h0;
    end
    else
    begin
      timer_flag_reg <= next_flags;
      irq_req        <= next_flags & timer_mask_reg;
    end
  end

  // software control registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_control_a    <= 3'h0;
      tick_source_select <= `DWT_SEL_STOP;
      timer_mask_reg     <= 4'h0;
    end
    else if (wr_en)
    begin
      case (paddr)
        `DWT_ADDR_CTRL_A:
          timer_control_a <= pwdata[2:0];
        `DWT_ADDR_CTRL_B:
          tick_source_select <= pwdata[2:0];
        `DWT_ADDR_MASK:
          timer_mask_reg <= pwdata[3:0];
        default:
          timer_mask_reg <= timer_mask_reg;
      endcase
    end
  end

  // compare registers; capture copies the count in
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      compare_reg_a <= `DWT_RST_BYTE;
      compare_reg_b <= `DWT_RST_BYTE;
    end
    else if (set_ev[`DWT_CAPT_BIT])
    begin
      // capture takes the count; b only in wide mode
      compare_reg_a <= count[7:0];
      if (width_select)
        compare_reg_b <= count[15:8];
    end
    else if (wr_en)
    begin
      // immediate update, no double buffering
      if (paddr == `DWT_ADDR_CMP_A)
        compare_reg_a <= pwdata[7:0];
      if (paddr == `DWT_ADDR_CMP_B)
        compare_reg_b <= pwdata[7:0];
    end
  end

  // sync hold and divider reset
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_hold_mode <= 1'b0;
      divider_reset  <= 1'b0;
    end
    else if (wr_en && paddr == `DWT_ADDR_GENERAL)
    begin
      sync_hold_mode <= pwdata[`DWT_HOLD_BIT];
      // hold off drops the reset
      divider_reset  <= pwdata[`DWT_DIVRST_BIT] &
                        pwdata[`DWT_HOLD_BIT] |
                        pwdata[`DWT_DIVRST_BIT] &
                        ~sync_hold_mode;
    end
    else if (!sync_hold_mode)
      divider_reset <= 1'b0;
    else
      divider_reset <= divider_reset;
  end

  // read mux and unmapped address check
  always @*
  begin
    next_rdata = 32'h00000000;
    next_err   = 1'b0;
    case (paddr)
      `DWT_ADDR_CTRL_A:
        next_rdata[2:0] = timer_control_a;
      `DWT_ADDR_CTRL_B:
        next_rdata[2:0] = tick_source_select;
      `DWT_ADDR_CNT_LO:
        next_rdata[7:0] = count[7:0];
      `DWT_ADDR_CNT_HI:
        next_rdata[7:0] = count[15:8];
      `DWT_ADDR_CMP_A:
        next_rdata[7:0] = compare_reg_a;
      `DWT_ADDR_CMP_B:
        next_rdata[7:0] = compare_reg_b;
      `DWT_ADDR_FLAGS:
        next_rdata[3:0] = timer_flag_reg;
      `DWT_ADDR_MASK:
        next_rdata[3:0] = timer_mask_reg;
      `DWT_ADDR_GENERAL:
      begin
        next_rdata[`DWT_HOLD_BIT]   = sync_hold_mode;
        next_rdata[`DWT_DIVRST_BIT] = divider_reset;
      end
      default:
        next_err = 1'b1;                        // unmapped
    endcase
  end

  // apb answer: one wait state, data held with pready
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (access && !pready)
    begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h00000000 : next_rdata;
      pslverr <= next_err;
    end
    else
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== dv/dwt_timer_props.sv ====
// port level assertions for the dual width timer
`timescale 1ns/100ps
`default_nettype none
module dwt_timer_props
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb slave side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // interrupt side
  input wire logic        capture_event,
  input wire logic [3:0]  int_ack,
  input wire logic [3:0]  irq_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // answer lasts one cycle, one wait state after access starts
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_lat: assert property (psel && $rose(penable) |=> pready)
    else $error("pready not one cycle after access");
  chk_ready_cause: assert property (pready |-> psel && $past(penable))
    else $error("pready without access phase");
  // error only with the answer, only for unmapped places
  chk_err_pair: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // misaligned places are unmapped as well as those past the map
  chk_err_unmapped: assert property (pready && (paddr > 8'h20 || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access not refused");
  chk_ok_mapped: assert property (pready && paddr <= 8'h20 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  // serviced capture request drops at once
  chk_ack_clears: assert property (int_ack[3] && !capture_event |=> !irq_req[3])
    else $error("capture request kept after service");
  cov_err: cover property (pslverr);
  cov_write: cover property (pready && pwrite);
  cov_ovf: cover property (irq_req[0]);
  cov_cap: cover property ($fell(irq_req[3]));
endmodule
bind dwt_timer dwt_timer_props dwt_timer_props_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .capture_event(capture_event), .int_ack(int_ack), .irq_req(irq_req));
`default_nettype wire

// ==== dv/tb_dwt_timer.sv ====
// self-checking bench for the dual width timer
`timescale 1ns/100ps
`default_nettype none
`include "dwt_consts.vh"
module tb_dwt_timer;
  logic        pclk, presetn;          // clock and active low reset
  logic        psel, penable, pwrite;  // apb request
  logic [7:0]  paddr;                  // byte address
  logic [31:0] pwdata, prdata, q, p;   // data and last read
  logic        pready, pslverr, last_err;
  logic        ext_count_pin, capture_event;
  logic [3:0]  int_ack, irq_req;
  int          errors, check_count;
  int          div_tab [4] = '{8, 64, 256, 1024};
  dwt_timer dwt_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_pin(ext_count_pin), .capture_event(capture_event),
    .int_ack(int_ack), .irq_req(irq_req));
  // 250 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // counts and verdict, ends the run
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // compare seen against expected
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer, held until pready is sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // pready is sampled at rising edges only
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 20)
    begin
      errors++;
      print_verdict();
    end
    // answer taken and request released at the same edge
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // read and compare, or read and range check
  task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  task rng(input logic [7:0] a, input int lo, input int hi, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, {31'h0, (q >= lo && q <= hi)}, 32'h1);
  endtask
  // bounded wait for one request bit
  task wirq(input int i);
    int n;
    n = 0;
    while (irq_req[i] !== 1'b1 && n < 3000)
    begin
      @(negedge pclk);
      n++;
    end
    chk("irq wait", {31'h0, irq_req[i]}, 32'h1);
    if (n == 3000)
      print_verdict();
  endtask
  // one-cycle pulses on service or capture inputs
  task pulse(input logic [3:0] m, input logic c);
    @(posedge pclk);
    int_ack <= m;
    capture_event <= c;
    @(posedge pclk);
    int_ack <= 4'h0;
    capture_event <= 1'b0;
    repeat (2) @(negedge pclk);
  endtask
  // reset values, field widths, unmapped place
  task t_regs;
    for (int i = 0; i <= 8; i++)
      rdc(8'(i * 4), 32'h0, "reset value");
    wr(`DWT_ADDR_CTRL_B, 32'hFF);
    rdc(`DWT_ADDR_CTRL_B, 32'h7, "select width");
    wr(`DWT_ADDR_GENERAL, 32'h7E);
    rdc(`DWT_ADDR_GENERAL, 32'h0, "general bits");
    apb(1'b1, 8'h24, 32'hFF);
    chk("unmapped err", {31'h0, last_err}, 32'h1);
    wr(`DWT_ADDR_CTRL_B, 32'h0);
    $display("test regs done");
  endtask
  // 8-bit wrap, overflow flag, service, stop, write priority
  task t_ovf;
    wr(`DWT_ADDR_MASK, 32'hF);
    wr(`DWT_ADDR_CNT_LO, 32'hF0);
    wr(`DWT_ADDR_CTRL_B, 32'h1);
    wirq(0);
    wr(`DWT_ADDR_CTRL_B, 32'h0);
    rng(`DWT_ADDR_CNT_LO, 1, 8, "wrapped");
    p = q;
    rdc(`DWT_ADDR_CNT_LO, p, "held");
    pulse(4'h1, 1'b0);
    chk("ovf serviced", {31'h0, irq_req[0]}, 32'h0);
    wr(`DWT_ADDR_CTRL_B, 32'h1);
    wr(`DWT_ADDR_CNT_LO, 32'h40);
    wr(`DWT_ADDR_CTRL_B, 32'h0);
    rng(`DWT_ADDR_CNT_LO, 8'h40, 8'h46, "write wins");
    wr(`DWT_ADDR_FLAGS, 32'hF);
    $display("test overflow done");
  endtask
  // clear on compare match, 8-bit
  task t_ctc;
    wr(`DWT_ADDR_CTRL_A, 32'h1);
    wr(`DWT_ADDR_CMP_A, 32'h5);
    wr(`DWT_ADDR_CNT_LO, 32'h0);
    wr(`DWT_ADDR_FLAGS, 32'hF);
    wr(`DWT_ADDR_CTRL_B, 32'h1);
    repeat (4) rng(`DWT_ADDR_CNT_LO, 0, 5, "ctc count");
    wr(`DWT_ADDR_CTRL_B, 32'h0);
    apb(1'b0, `DWT_ADDR_FLAGS, 32'h0);
    chk("ctc flags", q & 32'h3, 32'h2);
    wr(`DWT_ADDR_FLAGS, 32'hF);
    $display("test ctc done");
  endtask
  // 16-bit carry and overflow at 0xFFFF only
  task t_wide;
    wr(`DWT_ADDR_CTRL_A, 32'h2);
    wr(`DWT_ADDR_CNT_HI, 32'hFE);
    wr(`DWT_ADDR_CNT_LO, 32'hF0);
    wr(`DWT_ADDR_CTRL_B, 32'h1);
    repeat (20) @(posedge pclk);
    wr(`DWT_ADDR_CTRL_B, 32'h0);
    rdc(`DWT_ADDR_CNT_HI, 32'hFF, "carry");
    @(negedge pclk);
    chk("no 8-bit ovf", {31'h0, irq_req[0]}, 32'h0);
    wr(`DWT_ADDR_CTRL_B, 32'h1);
    wirq(0);
    wr(`DWT_ADDR_CTRL_B, 32'h0);
    rdc(`DWT_ADDR_CNT_HI, 32'h0, "wide wrap");
    pulse(4'h1, 1'b0);
    wr(`DWT_ADDR_FLAGS, 32'hF);
    $display("test wide done");
  endtask
  // capture copies count, mask gates request
  task t_cap;
    wr(`DWT_ADDR_CTRL_A, 32'h4);
    wr(`DWT_ADDR_MASK, 32'h0);
    wr(`DWT_ADDR_CNT_LO, 32'h33);
    pulse(4'h0, 1'b1);
    chk("masked", {31'h0, irq_req[3]}, 32'h0);
    rdc(`DWT_ADDR_CMP_A, 32'h33, "captured");
    wr(`DWT_ADDR_MASK, 32'h8);
    repeat (2) @(negedge pclk);
    chk("unmasked", {31'h0, irq_req[3]}, 32'h1);
    pulse(4'h8, 1'b0);
    rdc(`DWT_ADDR_FLAGS, 32'h0, "cap serviced");
    wr(`DWT_ADDR_CTRL_A, 32'h0);
    $display("test capture done");
  endtask
  // sync hold keeps divider reset, release resumes
  task t_hold;
    wr(`DWT_ADDR_GENERAL, 32'h81);
    rdc(`DWT_ADDR_GENERAL, 32'h81, "hold kept");
    wr(`DWT_ADDR_CNT_LO, 32'h0);
    wr(`DWT_ADDR_CTRL_B, 32'h2);
    repeat (100) @(posedge pclk);
    rdc(`DWT_ADDR_CNT_LO, 32'h0, "halted");
    wr(`DWT_ADDR_GENERAL, 32'h0);
    rdc(`DWT_ADDR_GENERAL, 32'h0, "released");
    repeat (40) @(posedge pclk);
    wr(`DWT_ADDR_CTRL_B, 32'h0);
    rng(`DWT_ADDR_CNT_LO, 3, 8, "resumed");
    wr(`DWT_ADDR_GENERAL, 32'h1);
    rdc(`DWT_ADDR_GENERAL, 32'h0, "self clear");
    $display("test hold done");
  endtask
  // every divider tap for four periods
  task t_div;
    for (int i = 0; i < 4; i++)
    begin
      wr(`DWT_ADDR_CNT_LO, 32'h0);
      wr(`DWT_ADDR_CTRL_B, 32'(i + 2));
      repeat (4 * div_tab[i]) @(posedge pclk);
      wr(`DWT_ADDR_CTRL_B, 32'h0);
      rng(`DWT_ADDR_CNT_LO, 3, 5, "tap rate");
    end
    $display("test divider done");
  endtask
  // pin edges: rising then falling, 5 wanted and 4 other
  task t_pin;
    for (int e = 0; e < 2; e++)
    begin
      wr(`DWT_ADDR_CNT_LO, 32'h0);
      wr(`DWT_ADDR_CTRL_B, 32'(7 - e));
      repeat (9)
      begin
        @(posedge pclk);
        ext_count_pin <= ~ext_count_pin;
        repeat (4) @(posedge pclk);
      end
      repeat (6) @(posedge pclk);
      wr(`DWT_ADDR_CTRL_B, 32'h0);
      rdc(`DWT_ADDR_CNT_LO, 32'h5, "pin edges");
    end
    $display("test pin done");
  endtask
  // reset, then all scenarios
  initial
  begin
    {psel, penable, pwrite, ext_count_pin, capture_event} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    int_ack = 4'h0;
    presetn = 1'b0;
    errors = 0;
    check_count = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_ovf();
    t_ctc();
    t_wide();
    t_cap();
    t_hold();
    t_div();
    t_pin();
    print_verdict();
  end
endmodule
`default_nettype wire
